// ---- logic/lbicd_cfg.svh ----
`ifndef LBICD_CFG_SVH
`define LBICD_CFG_SVH
// Instruction opcode fields
`define LBICD_ICON_CTL_OP 5'h01
`define LBICD_TEMP_OP 6'h04
`define LBICD_MULT_OP 6'h10
`define LBICD_BIAS_BIT 7
`define LBICD_BIAS_SEL_BIT 6
// Reset values and the reserved stage code
`define LBICD_TC_RST 2'h0
`define LBICD_STAGE_RST 2'h0
`define LBICD_BIAS_RST 6'h00
`define LBICD_STAGE_RSVD 2'h3
// Generator stage enables, thermometer coded
`define LBICD_STAGE_EN_ONE 3'h1
`define LBICD_STAGE_EN_TWO 3'h3
`define LBICD_STAGE_EN_THREE 3'h7
// Icon map geometry
`define LBICD_ODD_OFS 6'h20
`define LBICD_ROW18_OFS 6'h10
`define LBICD_ICONS_PER_ADDR 5
`endif

// ---- logic/lbicd_icon_map.sv ----
`timescale 1ns/1ps
`include "lbicd_cfg.svh"
// Maps an icon row/column to a pattern RAM address and bit; result registered
module lbicd_icon_map (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [6:0] col_idx,
    input wire logic row18,
    input wire logic odd_phase,
    output logic [5:0] addr,
    output logic [2:0] bit_idx
);
    logic [5:0] addr_nxt;
    logic [2:0] bit_nxt;
    logic [6:0] grp;
    logic [6:0] rem;

    // Five columns per address, bit 4 holds the leftmost column
    always_comb begin
        grp = col_idx / 7'(`LBICD_ICONS_PER_ADDR);
        rem = col_idx - grp * 7'(`LBICD_ICONS_PER_ADDR);
        addr_nxt = grp[5:0];
        if (row18) begin
            addr_nxt = addr_nxt + `LBICD_ROW18_OFS;
        end
        if (odd_phase) begin
            addr_nxt = addr_nxt + `LBICD_ODD_OFS;
        end
        bit_nxt = 3'(`LBICD_ICONS_PER_ADDR - 1) - rem[2:0];
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr <= 6'h00;
            bit_idx <= 3'h0;
        end else begin
            addr <= addr_nxt;
            bit_idx <= bit_nxt;
        end
    end
endmodule

// ---- logic/lbicd_pkg.sv ----
package lbicd_pkg;
    typedef logic [1:0] lbicd_sel_t;
    typedef logic [5:0] lbicd_bias_t;
    typedef enum logic [1:0] {
        LBICD_TC0,
        LBICD_TC1,
        LBICD_TC2,
        LBICD_TC3
    } lbicd_tc_t;
endpackage

// ---- logic/lbicd_top.sv ----
`timescale 1ns/1ps
`include "lbicd_cfg.svh"
module lbicd_top
    import lbicd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic INSTR_WR,
    input wire logic REGISTER_SELECT,
    input wire logic READ_NWRITE,
    input wire logic [7:0] INSTR_DATA,
    input wire logic EXT_SET,
    input wire logic DISPLAY_ON,
    input wire logic POWER_DOWN,
    input wire logic CURSOR_BLINK_ON,
    input wire logic [6:0] ICON_COL,
    input wire logic ICON_ROW18,
    input wire logic [4:0] PATTERN_DATA,
    output logic [5:0] PATTERN_ADDR,
    output logic ICON_SEG,
    output logic ICON_ONLY_FLAG,
    output logic ICON_FLASH_ENABLE,
    output logic SUPPLY_PASSTHROUGH_FLAG,
    output logic BIAS_TO_SUPPLY,
    output lbicd_pkg::lbicd_tc_t TEMP_COEFF_SELECT,
    output logic [2:0] STAGE_ENABLE,
    output lbicd_pkg::lbicd_bias_t BIAS_FACTOR,
    output logic GEN_ENABLE
);
    import lbicd_pkg::*;

    logic icon_only_r, icon_only_nxt;
    logic flash_r, flash_nxt;
    logic pass_r, pass_nxt;
    lbicd_sel_t tc_r, tc_nxt;
    lbicd_sel_t stage_r, stage_nxt;
    lbicd_bias_t bias_char_r, bias_char_nxt;
    lbicd_bias_t bias_icon_r, bias_icon_nxt;
    logic ext_wr;
    logic [2:0] bit_idx;
    logic odd_phase;
    logic seg_r, seg_nxt;
    logic gen_r, gen_nxt;
    lbicd_bias_t bias_sel;
    lbicd_tc_t tc_out_r, tc_out_nxt;
    logic [2:0] stage_en_r, stage_en_nxt;
    lbicd_bias_t bias_out_r, bias_out_nxt;

    // Opcode matchers, shared by the decoder and its checks
    function automatic logic is_icon_ctl(input logic [7:0] d);
        return d[7:3] == `LBICD_ICON_CTL_OP;
    endfunction
    function automatic logic is_temp(input logic [7:0] d);
        return d[7:2] == `LBICD_TEMP_OP;
    endfunction
    function automatic logic is_mult(input logic [7:0] d);
        return d[7:2] == `LBICD_MULT_OP;
    endfunction

    // Stage count as a thermometer; code 11 never reaches the register
    function automatic logic [2:0] stage_therm(input lbicd_sel_t sel);
        logic [2:0] en;
        unique case (sel)
            2'h0: en = `LBICD_STAGE_EN_ONE;
            2'h1: en = `LBICD_STAGE_EN_TWO;
            2'h2: en = `LBICD_STAGE_EN_THREE;
            default: en = `LBICD_STAGE_EN_ONE;
        endcase
        return en;
    endfunction

    // Coefficient codes are not in binary order: 00,10,01,11 give 0..3
    function automatic lbicd_tc_t tc_order(input lbicd_sel_t sel);
        lbicd_tc_t tc;
        unique case (sel)
            2'h0: tc = LBICD_TC0;
            2'h2: tc = LBICD_TC1;
            2'h1: tc = LBICD_TC2;
            2'h3: tc = LBICD_TC3;
        endcase
        return tc;
    endfunction

    // Mode picks which of the two bias factors drives the generator
    function automatic lbicd_bias_t bias_pick(input logic icon_mode, input lbicd_bias_t char_val,
        input lbicd_bias_t icon_val);
        return icon_mode ? icon_val : char_val;
    endfunction

    // Only RS=0, R/W=0 writes in the extended set are candidates
    assign ext_wr = INSTR_WR && !REGISTER_SELECT && !READ_NWRITE && EXT_SET;

    // Instruction decode for the extended-set registers
    always_comb begin
        icon_only_nxt = icon_only_r;
        flash_nxt = flash_r;
        pass_nxt = pass_r;
        tc_nxt = tc_r;
        stage_nxt = stage_r;
        bias_char_nxt = bias_char_r;
        bias_icon_nxt = bias_icon_r;
        if (ext_wr) begin
            if (INSTR_DATA[`LBICD_BIAS_BIT]) begin
                // Bias write wins whole opcode space with bit 7 set
                if (INSTR_DATA[`LBICD_BIAS_SEL_BIT]) begin
                    bias_icon_nxt = INSTR_DATA[5:0];
                end else begin
                    bias_char_nxt = INSTR_DATA[5:0];
                end
            end else if (is_icon_ctl(INSTR_DATA)) begin
                icon_only_nxt = INSTR_DATA[2];
                flash_nxt = INSTR_DATA[1];
                pass_nxt = INSTR_DATA[0];
            end else if (is_temp(INSTR_DATA)) begin
                tc_nxt = INSTR_DATA[1:0];
            end else if (is_mult(INSTR_DATA)) begin
                // Reserved code would leave stages undefined, so ignore it
                if (INSTR_DATA[1:0] != `LBICD_STAGE_RSVD) begin
                    stage_nxt = INSTR_DATA[1:0];
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            icon_only_r <= 1'b0;
            flash_r <= 1'b0;
            pass_r <= 1'b0;
            tc_r <= `LBICD_TC_RST;
            stage_r <= `LBICD_STAGE_RST;
            bias_char_r <= `LBICD_BIAS_RST;
            bias_icon_r <= `LBICD_BIAS_RST;
        end else begin
            icon_only_r <= icon_only_nxt;
            flash_r <= flash_nxt;
            pass_r <= pass_nxt;
            tc_r <= tc_nxt;
            stage_r <= stage_nxt;
            bias_char_r <= bias_char_nxt;
            bias_icon_r <= bias_icon_nxt;
        end
    end

    // Odd phase is the cursor-off half, only when blinking
    assign odd_phase = flash_r && !CURSOR_BLINK_ON;

    lbicd_icon_map u_map (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .col_idx(ICON_COL),
        .row18(ICON_ROW18),
        .odd_phase(odd_phase),
        .addr(PATTERN_ADDR),
        .bit_idx(bit_idx)
    );

    assign bias_sel = bias_pick(icon_only_r, bias_char_r, bias_icon_r);

    // Decoded outputs taken from next state, so they come from flops at no extra latency
    always_comb begin
        stage_en_nxt = stage_therm(stage_nxt);
        tc_out_nxt = tc_order(tc_nxt);
        bias_out_nxt = bias_pick(icon_only_nxt, bias_char_nxt, bias_icon_nxt);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stage_en_r <= `LBICD_STAGE_EN_ONE;
            tc_out_r <= LBICD_TC0;
            bias_out_r <= `LBICD_BIAS_RST;
        end else begin
            stage_en_r <= stage_en_nxt;
            tc_out_r <= tc_out_nxt;
            bias_out_r <= bias_out_nxt;
        end
    end

    // Segment and generator enable, registered
    always_comb begin
        seg_nxt = PATTERN_DATA[bit_idx];
        gen_nxt = !pass_r && DISPLAY_ON && !POWER_DOWN
            && (bias_sel != `LBICD_BIAS_RST);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seg_r <= 1'b0;
            gen_r <= 1'b0;
        end else begin
            seg_r <= seg_nxt;
            gen_r <= gen_nxt;
        end
    end

    assign STAGE_ENABLE = stage_en_r;
    assign TEMP_COEFF_SELECT = tc_out_r;
    assign ICON_SEG = seg_r;
    assign ICON_ONLY_FLAG = icon_only_r;
    assign ICON_FLASH_ENABLE = flash_r;
    assign SUPPLY_PASSTHROUGH_FLAG = pass_r;
    assign BIAS_TO_SUPPLY = pass_r;
    assign BIAS_FACTOR = bias_out_r;
    assign GEN_ENABLE = gen_r;

    property p_bias_char;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && INSTR_DATA[7:6] == 2'h2 |=> bias_char_r == $past(INSTR_DATA[5:0]);
    endproperty
    a_bias_char: assert property (p_bias_char) else $error("char bias not loaded");

    property p_bias_icon;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && INSTR_DATA[7:6] == 2'h3 |=> $stable(bias_char_r);
    endproperty
    a_bias_icon: assert property (p_bias_icon) else $error("icon write hit char bias");

    property p_temp;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && INSTR_DATA[7:2] == 6'h04 |=> tc_r == $past(INSTR_DATA[1:0]);
    endproperty
    a_temp: assert property (p_temp) else $error("temp coeff not loaded");

    property p_rsvd;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && INSTR_DATA == 8'h43 |=> $stable(stage_r);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved stage accepted");

    property p_noext;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !EXT_SET |=> $stable(tc_r) && $stable(stage_r) && $stable(pass_r);
    endproperty
    a_noext: assert property (p_noext) else $error("decode outside extended set");

    property p_gen_off;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (POWER_DOWN || !DISPLAY_ON || pass_r) |=> !GEN_ENABLE;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("generator on while disabled");

    property p_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
        bias_sel == 6'h00 |=> !GEN_ENABLE;
    endproperty
    a_zero: assert property (p_zero) else $error("generator on with zero bias");

    property p_mode;
        @(posedge SYS_CLK) disable iff (!RST_N)
        icon_only_r |-> BIAS_FACTOR == bias_icon_r;
    endproperty
    a_mode: assert property (p_mode) else $error("wrong bias for icon mode");

    sequence s_odd_req;
        odd_phase && ICON_COL == 7'h00 && !ICON_ROW18;
    endsequence
    property p_odd_addr;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_odd_req |=> PATTERN_ADDR == 6'h20;
    endproperty
    a_odd_addr: assert property (p_odd_addr) else $error("odd phase address wrong");

    property p_icon_load;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && INSTR_DATA[7:6] == 2'h3 |=> bias_icon_r == $past(INSTR_DATA[5:0]);
    endproperty
    a_icon_load: assert property (p_icon_load) else $error("icon bias not loaded");

    property p_ctl_flags;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && is_icon_ctl(INSTR_DATA) |=>
            {ICON_ONLY_FLAG, ICON_FLASH_ENABLE, SUPPLY_PASSTHROUGH_FLAG}
            == $past(INSTR_DATA[2:0]);
    endproperty
    a_ctl_flags: assert property (p_ctl_flags) else $error("icon flags not loaded");

    property p_gen_on;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !pass_r && DISPLAY_ON && !POWER_DOWN && bias_sel != `LBICD_BIAS_RST |=> GEN_ENABLE;
    endproperty
    a_gen_on: assert property (p_gen_on) else $error("generator off while enabled");

    property p_tc_out;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && is_temp(INSTR_DATA) |=>
            2'(TEMP_COEFF_SELECT) == {$past(INSTR_DATA[0]), $past(INSTR_DATA[1])};
    endproperty
    a_tc_out: assert property (p_tc_out) else $error("coefficient order wrong");

    property p_stage_out;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ext_wr && INSTR_DATA == {`LBICD_MULT_OP, 2'h2} |=>
            STAGE_ENABLE == `LBICD_STAGE_EN_THREE;
    endproperty
    a_stage_out: assert property (p_stage_out) else $error("quadrupler stages wrong");

    sequence s_even_req;
        !odd_phase && ICON_COL == 7'h00 && !ICON_ROW18;
    endsequence
    property p_even_addr;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_even_req |=> PATTERN_ADDR == 6'h00;
    endproperty
    a_even_addr: assert property (p_even_addr) else $error("even phase address wrong");
endmodule

// ---- testbench/lbicd_host.sv ----
`timescale 1ns/1ps
// Host side: one-cycle instruction write, with the extended-set flag taken from e
module lbicd_host (
    input wire logic clk,
    output logic wr,
    output logic rs,
    output logic rw,
    output logic [7:0] data,
    output logic ext
);
    // Idle bus at time zero
    initial begin
        wr = 1'b0;
        rs = 1'b1;
        rw = 1'b1;
        data = 8'h00;
        ext = 1'b0;
    end
    // Data is inverted once the strobe drops, so a stale byte never matches
    task automatic put(input logic [7:0] d, input logic e, input logic [1:0] q);
        @(posedge clk);
        ext <= e;
        wr <= 1'b1;
        {rs, rw} <= q;
        data <= d;
        @(posedge clk);
        wr <= 1'b0;
        ext <= 1'b0;
        data <= ~d;
    endtask
endmodule

// ---- testbench/lcd_bias_and_icon_command_decode_test.sv ----
`timescale 1ns/1ps
module lcd_bias_and_icon_command_decode_test;
    import lbicd_pkg::*;
    logic clk, rst_n, wr, rs, rw, ext, disp, pd, blink, row, seg, icm, fl, pass, sup, gen;
    logic [7:0] data, d;
    logic [6:0] col;
    logic [4:0] pdat;
    logic [5:0] paddr, a;
    lbicd_tc_t tcs;
    logic [2:0] stage_en;
    lbicd_bias_t bias;
    logic [1:0] tc, stg;
    logic [5:0] va, vb;
    logic im, ib, dm;
    int error_cnt, n_compared, c;
    logic [8:0] cw[9] = '{9'h185, 9'h180, 9'h1ff, 9'h10c, 9'h143, 9'h113, 9'h10b, 9'h142, 9'h100};

    lbicd_top i_lbicd_top (.SYS_CLK(clk), .RST_N(rst_n), .INSTR_WR(wr), .REGISTER_SELECT(rs),
        .READ_NWRITE(rw), .INSTR_DATA(data), .EXT_SET(ext), .DISPLAY_ON(disp),
        .POWER_DOWN(pd), .CURSOR_BLINK_ON(blink), .ICON_COL(col), .ICON_ROW18(row),
        .PATTERN_DATA(pdat), .PATTERN_ADDR(paddr), .ICON_SEG(seg), .ICON_ONLY_FLAG(icm),
        .ICON_FLASH_ENABLE(fl), .SUPPLY_PASSTHROUGH_FLAG(pass), .BIAS_TO_SUPPLY(sup),
        .TEMP_COEFF_SELECT(tcs), .STAGE_ENABLE(stage_en), .BIAS_FACTOR(bias), .GEN_ENABLE(gen));
    lbicd_host i_lbicd_host (.clk(clk), .wr(wr), .rs(rs), .rw(rw), .data(data), .ext(ext));

    // Pattern RAM stand-in: a fixed scramble of the address
    function automatic logic [4:0] pat(input logic [5:0] x);
        return x[4:0] ^ {x[5], 4'ha};
    endfunction
    assign pdat = pat(paddr);

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic finish_test;
        $display("errors=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Write through the host, update the model, check one edge after the take
    task automatic do_wr(input logic [7:0] x, input logic e, input logic [1:0] q);
        i_lbicd_host.put(x, e, q);
        if (e && q == 2'h0) begin
            if (x[7] && x[6]) vb = x[5:0];
            else if (x[7]) va = x[5:0];
            else if (x[7:3] == 5'h01) {im, ib, dm} = x[2:0];
            else if (x[7:2] == 6'h04) tc = x[1:0];
            else if (x[7:2] == 6'h10 && x[1:0] != 2'h3) stg = x[1:0];
        end
        disp <= ($urandom % 4) != 0;
        pd <= ($urandom % 4) == 0;
        @(posedge clk);
        #1;
        chk(8'(tcs), 8'({tc[0], tc[1]}));
        chk(8'(stage_en), (stg == 2'h0) ? 8'h01 : (stg == 2'h1) ? 8'h03 : 8'h07);
        chk(8'(bias), 8'(im ? vb : va));
        chk(8'({icm, fl, pass, sup}), 8'({im, ib, dm, dm}));
        chk(8'(gen), 8'(!dm && disp && !pd && (im ? vb : va) != 6'h0));
    endtask

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // Corner writes, random writes, then icon lookups in both blink states
    initial begin
        void'($urandom(76));
        {rst_n, disp, pd, blink, row, col} = '0;
        {tc, stg, va, vb, im, ib, dm} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        foreach (cw[i]) do_wr(cw[i][7:0], cw[i][8], 2'h0);
        repeat (200) begin
            d = 8'($urandom);
            case ($urandom % 5)
                0: d = 8'h80 | d;
                1: d = {5'h01, d[2:0]};
                2: d = {6'h04, d[1:0]};
                3: d = {6'h10, d[1:0]};
                default: d = d;
            endcase
            do_wr(d, ($urandom % 8) != 0, ($urandom % 8 == 0) ? 2'($urandom) : 2'h0);
        end
        do_wr(8'h02, 1'b1, 2'h0);
        for (int i = 0; i < 60; i++) begin
            if (i == 30) do_wr(8'h00, 1'b1, 2'h0);
            // First two lookups of each half hit column 0 with row 0 and column 79 with row 1
            c = (i % 30 == 0) ? 0 : (i % 30 == 1) ? 79 : $urandom % 80;
            @(posedge clk);
            col <= 7'(c);
            row <= (i % 30 < 2) ? 1'(i % 30) : 1'($urandom);
            blink <= (i % 30 < 2) ? 1'b0 : 1'($urandom);
            @(posedge clk);
            #1;
            a = 6'(c / 5) + (row ? 6'h10 : 6'h00) + ((ib && !blink) ? 6'h20 : 6'h00);
            chk(8'(paddr), 8'(a));
            @(posedge clk);
            #1;
            chk(8'(seg), 8'(pat(a) >> (4 - c % 5)) & 8'h01);
        end
        finish_test();
    end
endmodule
